/* hdl/sair_rx.sv */
// Overview of operation
// - Left/right aligned: frame select high carries left, low carries right.
// - At 64 x Fs each channel slot lasts 32 bit clocks.
// - At 48 x Fs aligned formats use 24-clock slots.
// - I2S also runs with 24-bit transfer words, 24-clock slots.
// - Left aligned: MSB arrives in the period frame select toggles.
// - Data is MSB first, captured on the bit clock rising edge.
// - Left aligned: positions after the last word bit are discarded.
// - Right aligned, 64 x Fs, 24-bit: first bit 8 clocks after toggle.
// - Right aligned: LSB is the last bit clock before the toggle.
// - Right aligned: positions before the first word bit are discarded.
// - Samples are two's complement in every format and word length.
// - I2S: frame select low carries left, high carries right.
// - I2S: MSB one bit clock after toggle; trailing positions ignored.
`default_nettype none

module sair_rx (
   // System side
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [1:0]  format_i,
   input  wire logic [1:0]  word_len_i,
   input  wire logic        short_slot_i,
   output logic             sample_valid_o,
   input  wire logic        sample_ready_i,
   output logic [23:0]      left_sample_o,
   output logic [23:0]      right_sample_o,
   output logic             frame_error_o,
   output logic             overrun_o,
   // Link side, on the bit clock
   input  wire logic        bit_clock_i,
   input  wire logic        frame_select_i,
   input  wire logic        serial_audio_data_in
);

   localparam int unsigned WW = sair_pkg::SAIR_WORD_W;
   localparam int unsigned HW = sair_pkg::SAIR_HIST_W;
   localparam int unsigned CW = sair_pkg::SAIR_CNT_W;

   // ---------------- Link domain ----------------

   logic          link_rst;
   logic [4:0]    cfg_link;
   logic          ack_link;
   logic          lr_q;
   logic          started;
   logic [CW-1:0] pos_q;
   logic [HW-1:0] hist;
   logic [WW-1:0] left_hold;
   logic          have_left;
   logic [WW-1:0] xfer_left;
   logic [WW-1:0] xfer_right;
   logic          req_tog;
   logic          err_tog;
   logic          ovr_tog;

   // Reset carried onto the bit clock
   sair_sync #(.WIDTH(1)) u_rst_sync (
      .clock_i (bit_clock_i),
      .clear_i (1'b0),
      .d_i     (rst_i),
      .q_o     (link_rst)
   );

   // Static configuration carried onto the bit clock
   sair_sync #(.WIDTH(5)) u_cfg_sync (
      .clock_i (bit_clock_i),
      .clear_i (link_rst),
      .d_i     ({short_slot_i, word_len_i, format_i}),
      .q_o     (cfg_link)
   );

   // Handshake return from the system domain
   logic ack_core;
   sair_sync #(.WIDTH(1)) u_ack_sync (
      .clock_i (bit_clock_i),
      .clear_i (link_rst),
      .d_i     (ack_core),
      .q_o     (ack_link)
   );

   // Configuration decode
   sair_pkg::sair_format_e fmt;
   sair_pkg::sair_wlen_e   wlen;
   wire                    short_slot = cfg_link[4];
   assign fmt  = sair_pkg::sair_format_e'(cfg_link[1:0]);
   assign wlen = sair_pkg::sair_wlen_e'(cfg_link[3:2]);

   wire is_i2s   = (fmt == sair_pkg::SAIR_FMT_I2S);
   wire is_left  = (fmt == sair_pkg::SAIR_FMT_LEFT_ALIGNED) ||
                   (fmt == sair_pkg::SAIR_FMT_SPARE);                    // Spare code falls back to left aligned
   wire is_right = (fmt == sair_pkg::SAIR_FMT_RIGHT_ALIGNED);

   // Word length in bit clocks
   function automatic logic [CW-1:0] len_of(input sair_pkg::sair_wlen_e w);
      unique case (w)
         sair_pkg::SAIR_WL_16: len_of = sair_pkg::SAIR_LEN_16;
         sair_pkg::SAIR_WL_20: len_of = sair_pkg::SAIR_LEN_20;
         default:              len_of = sair_pkg::SAIR_LEN_24;
      endcase
   endfunction : len_of

   // Low word bits placed at the top of 24, zero below
   function automatic logic [WW-1:0] align(input logic [HW-1:0] src, input sair_pkg::sair_wlen_e w);
      unique case (w)
         sair_pkg::SAIR_WL_16: align = {src[15:0], 8'h00};
         sair_pkg::SAIR_WL_20: align = {src[19:0], 4'h0};
         default:              align = src[23:0];
      endcase
   endfunction : align

   // Slot edge and bit position within the slot
   wire           toggle     = frame_select_i ^ lr_q;
   wire [CW-1:0]  pos_plus   = pos_q + CW'(1);
   wire [CW-1:0]  pos        = toggle ? '0 : ((pos_q == sair_pkg::SAIR_CNT_MAX) ? pos_q : pos_plus);
   wire [CW-1:0]  word_len   = len_of(wlen);
   wire [CW-1:0]  slot_len   = short_slot ? sair_pkg::SAIR_SLOT_48 : sair_pkg::SAIR_SLOT_64;
   wire [HW-1:0]  with_bit   = {hist[HW-2:0], serial_audio_data_in};

   // Completion of one channel word per framing
   wire done_left_al  = is_left && (pos == word_len - CW'(1));
   // A word that fills its whole I2S slot ends with its LSB on the next toggle edge
   wire i2s_tail      = is_i2s && toggle && started && (pos_plus == word_len);
   wire done_i2s      = (is_i2s && (pos == word_len)) || i2s_tail;
   wire done_right_al = is_right && toggle && started;
   wire word_done     = done_left_al || done_i2s || done_right_al;

   // Right aligned word ends one clock before the toggle, so it sits in the history
   wire [HW-1:0] src      = done_right_al ? hist : with_bit;
   wire [WW-1:0] word     = align(src, wlen);

   // Channel of the completed word
   wire chan_left = is_i2s   ? (i2s_tail ? ~lr_q : ~frame_select_i) :
                    is_right ? lr_q :
                               frame_select_i;

   // Slot length check on each toggle after the first
   wire slot_bad  = toggle && started && (pos_plus != slot_len);
   wire can_send  = (req_tog == ack_link);

   // Frame select history, position and shift history on the rising edge
   always_ff @(posedge bit_clock_i) begin
      if (link_rst) begin
         lr_q    <= 1'b0;
         started <= 1'b0;
         pos_q   <= sair_pkg::SAIR_CNT_MAX;
         hist    <= sair_pkg::SAIR_HIST_RST;
      end else begin
         lr_q  <= frame_select_i;
         pos_q <= pos;
         hist  <= with_bit;
         if (toggle) started <= 1'b1;
      end
   end

   // Left word held until its right partner completes the pair
   always_ff @(posedge bit_clock_i) begin
      if (link_rst) begin
         left_hold <= sair_pkg::SAIR_WORD_RST;
         have_left <= 1'b0;
      end else if (word_done) begin
         if (chan_left) left_hold <= word;
         have_left <= chan_left;
      end
   end

   // Pair offered to the system domain by a toggle handshake
   always_ff @(posedge bit_clock_i) begin
      if (link_rst) begin
         xfer_left  <= sair_pkg::SAIR_WORD_RST;
         xfer_right <= sair_pkg::SAIR_WORD_RST;
         req_tog    <= 1'b0;
         ovr_tog    <= 1'b0;
      end else if (word_done && !chan_left && have_left) begin
         if (can_send) begin
            xfer_left  <= left_hold;
            xfer_right <= word;
            req_tog    <= ~req_tog;
         end else begin
            ovr_tog <= ~ovr_tog;
         end
      end
   end

   // Slot length fault event
   always_ff @(posedge bit_clock_i) begin
      if (link_rst) err_tog <= 1'b0;
      else if (slot_bad) err_tog <= ~err_tog;
   end

   // ---------------- System domain ----------------

   logic [2:0] tog_sync;
   logic [2:0] tog_last;
   logic       buf_ready;

   // Request and event toggles brought onto the system clock
   sair_sync #(.WIDTH(3)) u_evt_sync (
      .clock_i (clock_i),
      .clear_i (rst_i),
      .d_i     ({ovr_tog, err_tog, req_tog}),
      .q_o     (tog_sync)
   );

   wire req_pending = tog_sync[0] ^ ack_core;
   wire push        = req_pending && buf_ready;

   // Acknowledge once the pair is in the buffer; a full buffer holds back the acknowledge, so later pairs overrun
   always_ff @(posedge clock_i) begin
      if (rst_i) ack_core <= 1'b0;
      else if (push) ack_core <= tog_sync[0];
   end

   // Event edges become one-cycle pulses
   always_ff @(posedge clock_i) begin
      if (rst_i) tog_last <= 3'h0;
      else tog_last <= tog_sync;
   end

   logic frame_error;
   logic overrun;
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         frame_error <= 1'b0;
         overrun     <= 1'b0;
      end else begin
         frame_error <= tog_sync[1] ^ tog_last[1];
         overrun     <= tog_sync[2] ^ tog_last[2];
      end
   end

   assign frame_error_o = frame_error;
   assign overrun_o     = overrun;

   // Two-entry buffer between the link and the consumer
   sair_buf2 #(
      .WIDTH (2 * WW),
      .DEPTH (sair_pkg::SAIR_BUF_DEPTH)
   ) u_buf (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .in_valid_i  (req_pending),
      .in_ready_o  (buf_ready),
      .in_data_i   ({xfer_left, xfer_right}),
      .out_valid_o (sample_valid_o),
      .out_ready_i (sample_ready_i),
      .out_data_o  ({left_sample_o, right_sample_o})
   );

endmodule : sair_rx

`default_nettype wire

/* hdl/sair_pkg.sv */
`default_nettype none

package sair_pkg;

   // Framing selected by the format input
   typedef enum logic [1:0] {
      SAIR_FMT_I2S,
      SAIR_FMT_LEFT_ALIGNED,
      SAIR_FMT_RIGHT_ALIGNED,
      SAIR_FMT_SPARE
   } sair_format_e;

   // Word length selected by the word length input
   typedef enum logic [1:0] {
      SAIR_WL_16,
      SAIR_WL_20,
      SAIR_WL_24,
      SAIR_WL_SPARE
   } sair_wlen_e;

   localparam int unsigned SAIR_WORD_W   = 24;            // Downstream sample width
   localparam int unsigned SAIR_HIST_W   = 32;            // Longest slot in bit clocks
   localparam int unsigned SAIR_CNT_W    = 6;             // Bit position counter width
   localparam logic [5:0]  SAIR_SLOT_64  = 6'h20;         // Slot length at 64 x Fs
   localparam logic [5:0]  SAIR_SLOT_48  = 6'h18;         // Slot length at 48 x Fs
   localparam logic [5:0]  SAIR_LEN_16   = 6'h10;
   localparam logic [5:0]  SAIR_LEN_20   = 6'h14;
   localparam logic [5:0]  SAIR_LEN_24   = 6'h18;
   localparam logic [5:0]  SAIR_CNT_MAX  = 6'h3F;         // Reset value, saturated position
   localparam logic [31:0] SAIR_HIST_RST = 32'h0000_0000;
   localparam logic [23:0] SAIR_WORD_RST = 24'h00_0000;
   localparam int unsigned SAIR_BUF_DEPTH = 2;

endpackage : sair_pkg

`default_nettype wire

/* hdl/sair_sync.sv */
`default_nettype none

// Two-stage synchroniser for levels and toggles, with a synchronous clear
module sair_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic             clear_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // First stage is read only by the second
   always_ff @(posedge clock_i) begin
      if (clear_i) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= d_i;
         stage2 <= stage1;
      end
   end

   assign q_o = stage2;

endmodule : sair_sync

`default_nettype wire

/* hdl/sair_buf2.sv */
`default_nettype none

// Small FIFO in flip-flops with valid and ready on both sides
module sair_buf2 #(
   parameter int unsigned WIDTH = 48,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;

   // Honest full and empty from the fill count
   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];

   // Pointer wrap at the buffer depth
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : bump

   // Pointers and fill count
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= bump(wr_ptr);
         if (pop) rd_ptr <= bump(rd_ptr);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage
   always_ff @(posedge clock_i) begin
      if (push) mem[wr_ptr] <= in_data_i;
   end

endmodule : sair_buf2

`default_nettype wire

/* sim/sair_rx_monitor.sv */
`default_nettype none

// Port checker for the serial audio receiver
module sair_rx_monitor (
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic [1:0]  word_len_i,
   input wire logic        sample_valid_o,
   input wire logic        sample_ready_i,
   input wire logic [23:0] left_sample_o,
   input wire logic [23:0] right_sample_o,
   input wire logic        frame_error_o,
   input wire logic        overrun_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // Pair offered but not taken, then the same pair still offered
   sequence s_held;
      sample_valid_o && !sample_ready_i;
   endsequence
   sequence s_kept;
      sample_valid_o && $stable(left_sample_o) && $stable(right_sample_o);
   endsequence
   property p_hold;
      s_held |=> s_kept;
   endproperty

   // Reset quiets valid and both flags, flags are single pulses, words are padded
   AST_RST_VALID: assert property (disable iff (1'b0) rst_i |=> !sample_valid_o)
      else $error("valid high after reset");
   AST_RST_FLAGS: assert property (disable iff (1'b0) rst_i |=> !frame_error_o && !overrun_o)
      else $error("flag high after reset");
   AST_ERR_PULSE: assert property (frame_error_o |=> !frame_error_o)
      else $error("frame error longer than one cycle");
   AST_OVR_PULSE: assert property (overrun_o |=> !overrun_o)
      else $error("overrun longer than one cycle");
   AST_OVR_FULL: assert property (overrun_o |-> $past(sample_valid_o))
      else $error("overrun while nothing was held");
   AST_HOLD: assert property (p_hold)
      else $error("pair changed before it was taken");
   AST_PAD16: assert property (sample_valid_o && word_len_i == 2'h0 |->
      left_sample_o[7:0] == 8'h00 && right_sample_o[7:0] == 8'h00)
      else $error("16-bit word not zero padded");
   AST_PAD20: assert property (sample_valid_o && word_len_i == 2'h1 |->
      left_sample_o[3:0] == 4'h0 && right_sample_o[3:0] == 4'h0)
      else $error("20-bit word not zero padded");
endmodule : sair_rx_monitor

bind sair_rx sair_rx_monitor sair_rx_monitor_inst (.clock_i, .rst_i, .word_len_i, .sample_valid_o,
   .sample_ready_i, .left_sample_o, .right_sample_o, .frame_error_o, .overrun_o);

`default_nettype wire

/* sim/sair_tx_model.sv */
`default_nettype none

// Far-side sender; the bit clock runs only while it sends
module sair_tx_model (
   output logic bit_clock_o,
   output logic frame_select_o,
   output logic data_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic tail;
   bit   has_tail;

   // Idle levels
   initial begin
      bit_clock_o = 1'b0;
      frame_select_o = 1'b0;
      data_o = 1'b0;
      has_tail = 1'b0;
   end

   // One slot of s bit clocks at level lvl carrying an n-bit word
   task automatic send_slot(input logic lvl, input int s, input int n, input int fmt, input logic [23:0] w);
      int   p;
      logic b;
      for (p = 0; p < s; p++) begin
         b = ~data_o; // Unused positions never repeat the last bit
         if (fmt == 2 && p >= s - n) b = w[23 - p + s - n];
         else if (fmt == 0 && p >= 1 && p <= n) b = w[24 - p];
         else if (fmt == 0 && p == 0 && has_tail) b = tail;
         else if (fmt != 0 && fmt != 2 && p < n) b = w[23 - p];
         data_o = b;
         frame_select_o = lvl;
         #3 bit_clock_o = 1'b1;
         #3 bit_clock_o = 1'b0;
      end
      has_tail = fmt == 0 && n == s && s > 0;
      tail = w[0];
   endtask : send_slot

   // Left slot then right slot
   task automatic send_pair(input int fmt, input int s, input int n, input logic [23:0] l, input logic [23:0] r);
      send_slot(fmt != 0, s, n, fmt, l);
      send_slot(fmt == 0, s, n, fmt, r);
   endtask : send_pair
endmodule : sair_tx_model

`default_nettype wire

/* sim/sair_rx_bench.sv */
`default_nettype none

module sair_rx_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock_i;
   logic        rst_i;
   logic [1:0]  format_i;
   logic [1:0]  word_len_i;
   logic        short_slot_i;
   logic        sample_ready_i;
   logic        sample_valid_o;
   logic [23:0] left_sample_o;
   logic [23:0] right_sample_o;
   logic        frame_error_o;
   logic        overrun_o;
   logic        bit_clock_i;
   logic        frame_select_i;
   logic        serial_audio_data_in;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          err_seen = 0;
   int          ovr_seen = 0;

   sair_rx sair_rx_inst (.clock_i, .rst_i, .format_i, .word_len_i, .short_slot_i, .sample_valid_o,
      .sample_ready_i, .left_sample_o, .right_sample_o, .frame_error_o, .overrun_o, .bit_clock_i,
      .frame_select_i, .serial_audio_data_in);
   sair_tx_model sair_tx_model_inst (.bit_clock_o(bit_clock_i), .frame_select_o(frame_select_i),
      .data_o(serial_audio_data_in));

   // System clock and flag pulse counters
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      if (frame_error_o === 1'b1) err_seen++;
      if (overrun_o === 1'b1) ovr_seen++;
   end

   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: sample %h, expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : chk_flag

   // Configure, reset with the bit clock running, then idle time ending in a right slot, no aligned toggle
   task automatic start(input int fmt, input int wl, input logic sh);
      @(negedge clock_i);
      format_i = fmt[1:0];
      word_len_i = wl[1:0];
      short_slot_i = sh;
      rst_i = 1'b1;
      sair_tx_model_inst.send_slot(1'b0, 6, 0, fmt, 24'h000000);
      repeat (8) @(negedge clock_i);
      rst_i = 1'b0;
      sair_tx_model_inst.send_slot(1'b0, 4, 0, fmt, 24'h000000);
      sair_tx_model_inst.send_slot(fmt == 0, sh ? 24 : 32, 0, fmt, 24'h000000);
      err_seen = 0;
      ovr_seen = 0;
   endtask : start

   // Wait for a pair, compare it and take it
   task automatic take(input logic [23:0] l, input logic [23:0] r);
      int i;
      @(negedge clock_i);
      for (i = 0; i < 60 && sample_valid_o !== 1'b1; i++) @(negedge clock_i);
      chk_flag(sample_valid_o, 1'b1);
      chk_word(left_sample_o, l);
      chk_word(right_sample_o, r);
      sample_ready_i = 1'b1;
      @(negedge clock_i);
      sample_ready_i = 1'b0;
   endtask : take

   // Every framing, word length and slot length code
   task automatic sc_formats();
      int f, w, s, n;
      logic [23:0] l, m;
      for (f = 0; f < 4; f++) for (w = 0; w < 4; w++) for (s = 0; s < 2; s++) begin
         n = w == 0 ? 16 : w == 1 ? 20 : 24;
         m = w == 0 ? 24'hFFFF00 : w == 1 ? 24'hFFFFF0 : 24'hFFFFFF;
         l = 24'h9C3A5F ^ 24'(f * 7 + w * 3 + s);
         start(f, w, s[0]);
         sair_tx_model_inst.send_pair(f, s ? 24 : 32, n, l, ~l);
         sair_tx_model_inst.send_slot(f != 0, 1, 0, f, 24'h000000);
         take(l & m, ~l & m);
         chk_flag(err_seen != 0, 1'b0);
      end
   endtask : sc_formats

   // Consumer stalls over four pairs; older pairs survive in order
   task automatic sc_overrun();
      int i;
      start(1, 2, 1'b0);
      for (i = 0; i < 4; i++) sair_tx_model_inst.send_pair(1, 32, 24, 24'(i * 24'h111111), 24'(~i));
      sair_tx_model_inst.send_slot(1'b1, 1, 0, 1, 24'h000000);
      repeat (8) @(negedge clock_i);
      chk_flag(ovr_seen != 0, 1'b1);
      take(24'h000000, 24'hFFFFFF);
      take(24'h111111, 24'hFFFFFE);
      sample_ready_i = 1'b1;
      repeat (4) @(negedge clock_i);
      sample_ready_i = 1'b0;
      chk_flag(sample_valid_o, 1'b0);
   endtask : sc_overrun

   // A left slot of the wrong length for each slot setting
   task automatic sc_frame_error();
      int s;
      for (s = 0; s < 2; s++) begin
         start(1, 2, s[0]);
         sair_tx_model_inst.send_slot(1'b1, s ? 32 : 31, 24, 1, 24'h123456);
         sair_tx_model_inst.send_slot(1'b0, s ? 24 : 32, 24, 1, 24'h654321);
         repeat (8) @(negedge clock_i);
         chk_flag(err_seen != 0, 1'b1);
      end
   endtask : sc_frame_error

   task automatic end_sim();
      if (mismatches == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      rst_i = 1'b1;
      format_i = 2'h0;
      word_len_i = 2'h0;
      short_slot_i = 1'b0;
      sample_ready_i = 1'b0;
      repeat (8) @(negedge clock_i);
      sc_formats();
      sc_overrun();
      sc_frame_error();
      end_sim();
   end

   // Watchdog
   initial begin
      #200us;
      mismatches++;
      end_sim();
   end
endmodule : sair_rx_bench

`default_nettype wire
